/* periodic_timer_interrupt_bench.sv */
`default_nettype none
module periodic_timer_interrupt_bench;
   timeunit 1ns;
   timeprecision 100ps;

   logic ref_clk, resetn, secTick, minTick, irqLine, pinData, pinOeN;
   logic [3:0] awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   int errTotal, nTests, n, m;
   // repeated mode table: preset, source, expected low time in cycles
   logic [7:0] pv[5] = '{8'h01, 8'h02, 8'h01, 8'h01, 8'h01};
   logic [1:0] sv[5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
   int lo[5] = '{3, 6, 10, 20, 20};

   // small divider and release counts keep the run short
   ptimr_periodic_timer #(.FAST_DIV(8), .RTN_122US_CYC(3), .RTN_244US_CYC(6),
      .RTN_7813US_CYC(10), .RTN_15625US_CYC(20)) dut_u (
      .ref_clk(ref_clk), .resetn(resetn), .secTick(secTick), .minTick(minTick),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .timerIrqOutN_o(pinData), .timerIrqOutN_oe_n(pinOeN)
   );

   ptimr_host_irq host_u (.pinData(pinData), .pinOeN(pinOeN), .irqLine(irqLine));

   // free-running 250 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   task automatic report_and_stop();
      if (errTotal == 0 && nTests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      nTests++;
      if (seen !== exp) begin
         errTotal++;
         $display("wrong value at %0t ns: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   // write: address and data offered together, each dropped once taken
   task automatic wr(input logic [3:0] a, input logic [31:0] d,
      input logic [1:0] er = ptimr_pkg::RESP_OKAY);
      int k;
      k = 0;
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         k++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && k < 50);
      bready <= 1'b0;
      chk(32'(bvalid), 32'h1, "write answer");
      chk(32'(bresp), 32'(er), "write response");
   endtask

   // read and compare data and response at the handshake edge
   task automatic rdc(input logic [3:0] a, input logic [31:0] ed,
      input logic [1:0] er = ptimr_pkg::RESP_OKAY);
      int k;
      k = 0;
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge ref_clk);
         k++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && k < 50);
      rready <= 1'b0;
      chk(32'(rvalid), 32'h1, "read answer");
      chk(rdata, ed, "read data");
      chk(32'(rresp), 32'(er), "read response");
   endtask

   // count edges until the wire shows lvl, giving up after lim
   task automatic waitPin(input logic lvl, input int lim, output int c);
      c = 0;
      while (irqLine !== lvl && c < lim) begin
         @(posedge ref_clk);
         c++;
      end
   endtask

   task automatic strobe(input logic s, input logic mn);
      @(posedge ref_clk);
      secTick <= s;
      minTick <= mn;
      @(posedge ref_clk);
      secTick <= 1'b0;
      minTick <= 1'b0;
   endtask

   // safe reconfiguration: stop, clear flag, drop enable, preset, then run
   task automatic setup(input logic [7:0] p, input logic [1:0] sel, input logic [31:0] ctrl);
      wr(ptimr_pkg::REG_TCTRL, 32'h0);
      wr(ptimr_pkg::REG_CTRL, 32'h01);
      wr(ptimr_pkg::REG_CTRL, 32'h00);
      wr(ptimr_pkg::REG_PRESET, {24'h0, p});
      wr(ptimr_pkg::REG_CTRL, ctrl);
      wr(ptimr_pkg::REG_TCTRL, {24'h0, 6'h20, sel});
   endtask

   // hang guard, far beyond the expected few thousand cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      errTotal++;
      report_and_stop();
   end

   initial begin
      {resetn, secTick, minTick, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
      {awaddr, araddr, wdata} = 40'h0;
      wstrb = 4'h1;
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      rdc(ptimr_pkg::REG_CTRL, 32'h0);
      rdc(ptimr_pkg::REG_TCTRL, 32'h0);
      rdc(ptimr_pkg::REG_PRESET, 32'h0);
      wr(ptimr_pkg::REG_TCTRL, 32'h7f);
      rdc(ptimr_pkg::REG_TCTRL, 32'h03);
      wr(ptimr_pkg::REG_CTRL, 32'hffff_fffb);
      rdc(ptimr_pkg::REG_CTRL, 32'h11);
      wr(4'hc, 32'h1, ptimr_pkg::RESP_SLVERR);
      rdc(4'hc, 32'h0, ptimr_pkg::RESP_SLVERR);
      // level mode, long period so bus work fits between expiries
      setup(8'h08, ptimr_pkg::SEL_4096HZ, 32'h01);
      waitPin(1'b0, 80, n);
      chk(32'(n >= 54 && n <= 68), 32'h1, "first interval");
      rdc(ptimr_pkg::REG_CTRL, 32'h05);
      wr(ptimr_pkg::REG_CTRL, 32'h04);
      waitPin(1'b1, 3, n);
      chk(32'(irqLine), 32'h1, "disabled pin");
      rdc(ptimr_pkg::REG_CTRL, 32'h04);
      wr(ptimr_pkg::REG_CTRL, 32'h05);
      waitPin(1'b0, 3, n);
      chk(32'(irqLine), 32'h0, "re-enabled pin");
      wr(ptimr_pkg::REG_CTRL, 32'h01);
      waitPin(1'b1, 3, n);
      chk(32'(irqLine), 32'h1, "pin after clear");
      rdc(ptimr_pkg::REG_CTRL, 32'h01);
      waitPin(1'b0, 64, n);
      chk(32'(irqLine), 32'h0, "next event");
      waitPin(1'b1, 70, n);
      chk(32'(n), 32'd70, "level held");
      wr(ptimr_pkg::REG_TCTRL, 32'h0);
      waitPin(1'b1, 20, n);
      chk(32'(n), 32'd20, "pin after stop");
      rdc(ptimr_pkg::REG_CTRL, 32'h05);
      // event with interrupt disabled: flag only
      setup(8'h02, ptimr_pkg::SEL_4096HZ, 32'h00);
      waitPin(1'b0, 40, n);
      chk(32'(n), 32'd40, "masked pin");
      rdc(ptimr_pkg::REG_CTRL, 32'h04);
      // a zero preset must leave the earlier preset of 3 in force
      wr(ptimr_pkg::REG_TCTRL, 32'h0);
      wr(ptimr_pkg::REG_CTRL, 32'h0);
      wr(ptimr_pkg::REG_PRESET, 32'h03);
      wr(ptimr_pkg::REG_PRESET, 32'h00);
      wr(ptimr_pkg::REG_CTRL, 32'h01);
      wr(ptimr_pkg::REG_TCTRL, 32'h80);
      waitPin(1'b0, 40, n);
      chk(32'(n >= 14 && n <= 28), 32'h1, "interval of three");
      // repeated mode over every source, flag not cleared between events
      for (int i = 0; i < 5; i++) begin
         setup(pv[i], sv[i], 32'h11);
         if (sv[i][1]) begin
            strobe(sv[i] == 2'h3, sv[i] == 2'h2);
            waitPin(1'b0, 30, n);
            chk(32'(n), 32'd30, "wrong strobe");
            strobe(sv[i] == 2'h2, sv[i] == 2'h3);
            waitPin(1'b0, 10, n);
            chk(32'(n < 10), 32'h1, "strobe event");
         end else begin
            waitPin(1'b0, 600, n);
         end
         waitPin(1'b1, 40, n);
         chk(32'(n >= lo[i] - 1 && n <= lo[i] + 1), 32'h1, "auto release");
         if (!sv[i][1]) begin
            waitPin(1'b0, 600, m);
            m = m + n;
            n = (sv[i] == 2'h0) ? 8 * int'(pv[i]) : 512 * int'(pv[i]);
            chk(32'(m <= n && m >= n - 8), 32'h1, "repeat interval");
         end
      end
      report_and_stop();
   end
endmodule
`default_nettype wire

/* ptimr_host_irq.sv */
`default_nettype none
// host side of the interrupt wire: open-drain line with a board pull-up
module ptimr_host_irq (
   input wire logic pinData,
   input wire logic pinOeN,
   output logic irqLine
);
   timeunit 1ns;
   timeprecision 100ps;

   // released line reads the pull-up level, never the last driven value
   assign irqLine = pinOeN ? 1'b1 : pinData;
endmodule
`default_nettype wire

/* ptimr_periodic_timer.sv */
// Our own choices: register access over AXI4-Lite and the address map.
`default_nettype none
// Function
// - timer event sets the event flag; it stays set until software clears it
// - writing 0 to the flag clears it; writing 1 does nothing
// - clearing the flag does not stop the countdown while run enable is 1
// - level mode: after clear, next 01h to 00h step sets flag, drives output
// - with irq enable 1 an event drives the interrupt output low
// - with irq enable 0 the output is never driven, and is released
// - level mode: enabling irq while flag is set drives output at once
// - period is source tick period times preset; four selectable sources
// - interval may be up to one source tick short, never longer
// - run enable rising starts countdown from the preset
// - count down once per source tick; event on 01h to 00h step
// - after each event reload preset and keep counting while running
// - while flag stays set, further expiries add no new level effect
// - clearing run enable keeps flag and asserted output
// - level mode: flag cleared releases the output regardless of irq enable
// - preset accepts 1 to 255; zero is refused
// - 1 Hz and 1/60 Hz sources are the calendar second and minute strobes
// - mode bit 0 is level mode, 1 is repeated pulse mode
// - repeated mode releases output after the auto release time
module ptimr_periodic_timer #(
   parameter int FAST_DIV = ptimr_pkg::FAST_DIV,
   parameter int RTN_122US_CYC = ptimr_pkg::RTN_122US_CYC,
   parameter int RTN_244US_CYC = ptimr_pkg::RTN_244US_CYC,
   parameter int RTN_7813US_CYC = ptimr_pkg::RTN_7813US_CYC,
   parameter int RTN_15625US_CYC = ptimr_pkg::RTN_15625US_CYC
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic secTick,
   input wire logic minTick,
   input wire logic [ptimr_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [ptimr_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ptimr_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [ptimr_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic timerIrqOutN_o,
   output logic timerIrqOutN_oe_n
);
   logic fastTick, slowTick, srcTick;
   // bus slave state
   logic awHeld_q, awHeld_d, wHeld_q, wHeld_d;
   logic [ptimr_pkg::ADDR_W-1:0] awAddr_q, awAddr_d, arAddr;
   logic [7:0] wByte_q, wByte_d;
   logic wLane_q, wLane_d;
   logic bValid_q, bValid_d, rValid_q, rValid_d;
   logic [1:0] bResp_q, bResp_d, rResp_q, rResp_d;
   logic [ptimr_pkg::DATA_W-1:0] rData_q, rData_d;
   logic doWrite, wrCtrl, wrTctrl, wrPreset, flagClr;
   // timer state
   logic irqEn_q, irqEn_d, mode_q, mode_d, runEn_q, runEn_d;
   logic [1:0] srcSel_q, srcSel_d;
   logic [7:0] preset_q, preset_d, cnt_q, cnt_d;
   logic flag_q, flag_d, drive_q, drive_d;
   logic [ptimr_pkg::RTN_W-1:0] rtn_q, rtn_d, rtnLoad;
   logic timerEvent, pulseActive;
   ptimr_pkg::ptimr_run_e state_q, state_d;

   ptimr_tick_gen #(
      .FAST_DIV(FAST_DIV)
   ) u_tick (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .fastTick(fastTick),
      .slowTick(slowTick)
   );

   // source select; 1 Hz and minute sources follow the calendar strobes
   always_comb begin
      case (srcSel_q)
         ptimr_pkg::SEL_4096HZ: srcTick = fastTick;
         ptimr_pkg::SEL_64HZ: srcTick = slowTick;
         ptimr_pkg::SEL_1HZ: srcTick = secTick;
         default: srcTick = minTick;
      endcase
   end

   // write channel: address and data captured in either order
   always_comb begin
      awHeld_d = awHeld_q;
      awAddr_d = awAddr_q;
      wHeld_d = wHeld_q;
      wByte_d = wByte_q;
      wLane_d = wLane_q;
      bValid_d = bValid_q;
      bResp_d = bResp_q;
      doWrite = awHeld_q && wHeld_q && !bValid_q;
      if (s_axi_awvalid && s_axi_awready) begin
         awHeld_d = 1'b1;
         awAddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wHeld_d = 1'b1;
         wByte_d = s_axi_wdata[7:0];
         wLane_d = s_axi_wstrb[0];
      end
      if (doWrite) begin
         awHeld_d = 1'b0;
         wHeld_d = 1'b0;
         bValid_d = 1'b1;
         case (awAddr_q)
            ptimr_pkg::REG_CTRL, ptimr_pkg::REG_TCTRL, ptimr_pkg::REG_PRESET:
               bResp_d = ptimr_pkg::RESP_OKAY;
            default: bResp_d = ptimr_pkg::RESP_SLVERR;
         endcase
      end else if (bValid_q && s_axi_bready) begin
         bValid_d = 1'b0;
      end
   end

   assign s_axi_awready = !awHeld_q && !bValid_q;
   assign s_axi_wready = !wHeld_q && !bValid_q;
   assign wrCtrl = doWrite && wLane_q && (awAddr_q == ptimr_pkg::REG_CTRL);
   assign wrTctrl = doWrite && wLane_q && (awAddr_q == ptimr_pkg::REG_TCTRL);
   assign wrPreset = doWrite && wLane_q && (awAddr_q == ptimr_pkg::REG_PRESET);
   assign flagClr = wrCtrl && !wByte_q[ptimr_pkg::BIT_FLAG];

   // read channel: one cycle answer; preset address shows the live count
   always_comb begin
      rValid_d = rValid_q;
      rData_d = rData_q;
      rResp_d = rResp_q;
      arAddr = s_axi_araddr;
      if (s_axi_arvalid && s_axi_arready) begin
         rValid_d = 1'b1;
         rData_d = '0;
         rResp_d = ptimr_pkg::RESP_OKAY;
         case (arAddr)
            ptimr_pkg::REG_CTRL: begin
               rData_d[ptimr_pkg::BIT_IRQ_EN] = irqEn_q;
               rData_d[ptimr_pkg::BIT_FLAG] = flag_q;
               rData_d[ptimr_pkg::BIT_MODE] = mode_q;
            end
            ptimr_pkg::REG_TCTRL: begin
               rData_d[ptimr_pkg::BIT_SEL_HI:ptimr_pkg::BIT_SEL_LO] = srcSel_q;
               rData_d[ptimr_pkg::BIT_RUN] = runEn_q;
            end
            ptimr_pkg::REG_PRESET: rData_d[7:0] = cnt_q;
            default: rResp_d = ptimr_pkg::RESP_SLVERR;
         endcase
      end else if (rValid_q && s_axi_rready) begin
         rValid_d = 1'b0;
      end
   end

   assign s_axi_arready = !rValid_q;

   // control bits; zero preset is refused and the old value stays
   always_comb begin
      irqEn_d = irqEn_q;
      mode_d = mode_q;
      runEn_d = runEn_q;
      srcSel_d = srcSel_q;
      preset_d = preset_q;
      if (wrCtrl) begin
         irqEn_d = wByte_q[ptimr_pkg::BIT_IRQ_EN];
         mode_d = wByte_q[ptimr_pkg::BIT_MODE];
      end
      if (wrTctrl) begin
         runEn_d = wByte_q[ptimr_pkg::BIT_RUN];
         srcSel_d = wByte_q[ptimr_pkg::BIT_SEL_HI:ptimr_pkg::BIT_SEL_LO];
      end
      if (wrPreset && (wByte_q != ptimr_pkg::CNT_ZERO)) begin
         preset_d = wByte_q;
      end
   end

   // countdown; prescaler is not aligned to start, so the first step
   // may come early by up to one source tick
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      timerEvent = 1'b0;
      case (state_q)
         ptimr_pkg::ST_STOP: begin
            if (runEn_q) begin
               state_d = ptimr_pkg::ST_RUN;
               cnt_d = preset_q;
            end
         end
         ptimr_pkg::ST_RUN: begin
            if (!runEn_q) begin
               state_d = ptimr_pkg::ST_STOP;
            end else if (srcTick) begin
               if (cnt_q == ptimr_pkg::CNT_ONE) begin
                  timerEvent = 1'b1;
                  cnt_d = preset_q;
               end else begin
                  cnt_d = cnt_q - 1'b1;
               end
            end
         end
         default: state_d = ptimr_pkg::ST_STOP;
      endcase
   end

   // sticky flag; a new event wins over a clear in the same cycle
   always_comb begin
      flag_d = timerEvent || (flag_q && !flagClr);
   end

   // auto release length for repeated mode, picked from source and preset
   always_comb begin
      case (srcSel_q)
         ptimr_pkg::SEL_4096HZ: rtnLoad = (preset_q == ptimr_pkg::CNT_ONE) ?
            ptimr_pkg::RTN_W'(RTN_122US_CYC) : ptimr_pkg::RTN_W'(RTN_244US_CYC);
         ptimr_pkg::SEL_64HZ: rtnLoad = (preset_q == ptimr_pkg::CNT_ONE) ?
            ptimr_pkg::RTN_W'(RTN_7813US_CYC) : ptimr_pkg::RTN_W'(RTN_15625US_CYC);
         default: rtnLoad = ptimr_pkg::RTN_W'(RTN_15625US_CYC);
      endcase
      rtn_d = rtn_q;
      if (timerEvent && (mode_q == ptimr_pkg::MODE_REPEAT)) begin
         rtn_d = rtnLoad;
      end else if (rtn_q != '0) begin
         rtn_d = rtn_q - 1'b1;
      end
   end

   assign pulseActive = (rtn_q != '0);

   // pin drive: level mode follows the flag, repeated mode the pulse
   always_comb begin
      if (mode_q == ptimr_pkg::MODE_LEVEL) begin
         drive_d = irqEn_q && flag_q;
      end else begin
         drive_d = irqEn_q && pulseActive;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         awHeld_q <= 1'b0;
         awAddr_q <= '0;
         wHeld_q <= 1'b0;
         wByte_q <= '0;
         wLane_q <= 1'b0;
         bValid_q <= 1'b0;
         bResp_q <= ptimr_pkg::RESP_OKAY;
         rValid_q <= 1'b0;
         rData_q <= '0;
         rResp_q <= ptimr_pkg::RESP_OKAY;
         irqEn_q <= 1'b0;
         mode_q <= ptimr_pkg::MODE_LEVEL;
         runEn_q <= 1'b0;
         srcSel_q <= ptimr_pkg::SEL_RST;
         preset_q <= ptimr_pkg::PRESET_RST;
         cnt_q <= ptimr_pkg::CNT_ZERO;
         state_q <= ptimr_pkg::ST_STOP;
         flag_q <= 1'b0;
         rtn_q <= '0;
         drive_q <= 1'b0;
      end else begin
         awHeld_q <= awHeld_d;
         awAddr_q <= awAddr_d;
         wHeld_q <= wHeld_d;
         wByte_q <= wByte_d;
         wLane_q <= wLane_d;
         bValid_q <= bValid_d;
         bResp_q <= bResp_d;
         rValid_q <= rValid_d;
         rData_q <= rData_d;
         rResp_q <= rResp_d;
         irqEn_q <= irqEn_d;
         mode_q <= mode_d;
         runEn_q <= runEn_d;
         srcSel_q <= srcSel_d;
         preset_q <= preset_d;
         cnt_q <= cnt_d;
         state_q <= state_d;
         flag_q <= flag_d;
         rtn_q <= rtn_d;
         drive_q <= drive_d;
      end
   end

   assign s_axi_bvalid = bValid_q;
   assign s_axi_bresp = bResp_q;
   assign s_axi_rvalid = rValid_q;
   assign s_axi_rdata = rData_q;
   assign s_axi_rresp = rResp_q;
   // open drain: data always low, enable low while pulling down
   assign timerIrqOutN_o = 1'b0;
   assign timerIrqOutN_oe_n = !drive_q;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   sequence seqStart;
      (state_q == ptimr_pkg::ST_STOP) && runEn_q;
   endsequence

   sequence seqExpire;
      (state_q == ptimr_pkg::ST_RUN) && runEn_q && srcTick && (cnt_q == ptimr_pkg::CNT_ONE);
   endsequence

   chk_flag_sticky: assert property (flag_q && !flagClr |=> flag_q)
      else $error("event flag dropped without a clear");
   chk_flag_clear: assert property (flag_q && flagClr && !timerEvent |=> !flag_q)
      else $error("event flag not cleared by zero write");
   chk_start_load: assert property (seqStart |=> cnt_q == $past(preset_q))
      else $error("countdown did not start from preset");
   chk_expire_reload: assert property (seqExpire |=> flag_q && cnt_q == $past(preset_q))
      else $error("expiry did not set flag and reload");
   chk_count_step: assert property ((state_q == ptimr_pkg::ST_RUN) && runEn_q && srcTick
      && (cnt_q > ptimr_pkg::CNT_ONE) |=> cnt_q == $past(cnt_q) - 8'h01)
      else $error("counter did not step down by one");
   chk_level_drive: assert property ((mode_q == ptimr_pkg::MODE_LEVEL) && flag_q && irqEn_q
      && !flagClr |=> !timerIrqOutN_oe_n)
      else $error("level mode output not driven");
   chk_irq_gate: assert property (!irqEn_q |=> timerIrqOutN_oe_n)
      else $error("output driven with irq enable low");
   chk_clear_release: assert property ((mode_q == ptimr_pkg::MODE_LEVEL) && !flag_q
      |=> timerIrqOutN_oe_n)
      else $error("output not released after flag clear");
   chk_stop_keep: assert property (wrTctrl && !wByte_q[ptimr_pkg::BIT_RUN] && flag_q
      && !flagClr |=> flag_q [*2])
      else $error("stopping the timer cleared the flag");
   chk_rtn_start: assert property (seqExpire ##0 (mode_q == ptimr_pkg::MODE_REPEAT)
      |=> rtn_q != '0)
      else $error("repeated mode pulse not started");
endmodule
`default_nettype wire

/* ptimr_pkg.sv */
`default_nettype none
package ptimr_pkg;
   // register byte offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_TCTRL = 4'h4;
   localparam logic [3:0] REG_PRESET = 4'h8;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;

   // field positions, control register
   localparam int BIT_IRQ_EN = 0;
   localparam int BIT_FLAG = 2;
   localparam int BIT_MODE = 4;
   // field positions, timer control register
   localparam int BIT_SEL_LO = 0;
   localparam int BIT_SEL_HI = 1;
   localparam int BIT_RUN = 7;

   // reset values and counter compare constants
   localparam logic [7:0] PRESET_RST = 8'h01;
   localparam logic [7:0] CNT_ONE = 8'h01;
   localparam logic [7:0] CNT_ZERO = 8'h00;
   localparam logic [1:0] SEL_RST = 2'h0;

   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // source tick encodings
   localparam logic [1:0] SEL_4096HZ = 2'h0;
   localparam logic [1:0] SEL_64HZ = 2'h1;
   localparam logic [1:0] SEL_1HZ = 2'h2;
   localparam logic [1:0] SEL_MIN = 2'h3;

   // output modes
   localparam logic MODE_LEVEL = 1'b0;
   localparam logic MODE_REPEAT = 1'b1;

   // clock and source rates
   localparam longint CLK_HZ = 250_000_000;
   localparam longint SRC_FAST_HZ = 4096;
   localparam longint SRC_SLOW_HZ = 64;
   localparam int FAST_DIV = int'(CLK_HZ / SRC_FAST_HZ);
   localparam int SLOW_RATIO = int'(SRC_FAST_HZ / SRC_SLOW_HZ);
   localparam int FAST_CNT_W = 16;
   localparam int SLOW_CNT_W = 6;

   // auto release times in ns, counts rounded down
   localparam longint RTN_122US_NS = 122_000;
   localparam longint RTN_244US_NS = 244_000;
   localparam longint RTN_7813US_NS = 7_813_000;
   localparam longint RTN_15625US_NS = 15_625_000;
   localparam longint NS_PER_S = 1_000_000_000;
   localparam int RTN_122US_CYC = int'(RTN_122US_NS * CLK_HZ / NS_PER_S);
   localparam int RTN_244US_CYC = int'(RTN_244US_NS * CLK_HZ / NS_PER_S);
   localparam int RTN_7813US_CYC = int'(RTN_7813US_NS * CLK_HZ / NS_PER_S);
   localparam int RTN_15625US_CYC = int'(RTN_15625US_NS * CLK_HZ / NS_PER_S);
   localparam int RTN_W = 22;

   // run state
   typedef enum logic [1:0] {
      ST_STOP = 2'b01,
      ST_RUN = 2'b10
   } ptimr_run_e;
endpackage
`default_nettype wire

/* ptimr_tick_gen.sv */
`default_nettype none
module ptimr_tick_gen #(
   parameter int FAST_DIV = ptimr_pkg::FAST_DIV
) (
   input wire logic ref_clk,
   input wire logic resetn,
   output logic fastTick,
   output logic slowTick
);
   logic [ptimr_pkg::FAST_CNT_W-1:0] fastCnt_q, fastCnt_d;
   logic [ptimr_pkg::SLOW_CNT_W-1:0] slowCnt_q, slowCnt_d;
   logic fastTick_q, fastTick_d;
   logic slowTick_q, slowTick_d;
   logic fastWrap;

   // free running prescaler, never restarted by the timer
   always_comb begin
      fastWrap = (fastCnt_q == ptimr_pkg::FAST_CNT_W'(FAST_DIV - 1));
      fastCnt_d = fastWrap ? '0 : fastCnt_q + 1'b1;
      slowCnt_d = slowCnt_q;
      if (fastWrap) begin
         slowCnt_d = slowCnt_q + 1'b1;
      end
      fastTick_d = fastWrap;
      slowTick_d = fastWrap &&
         (slowCnt_q == ptimr_pkg::SLOW_CNT_W'(ptimr_pkg::SLOW_RATIO - 1));
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         fastCnt_q <= '0;
         slowCnt_q <= '0;
         fastTick_q <= 1'b0;
         slowTick_q <= 1'b0;
      end else begin
         fastCnt_q <= fastCnt_d;
         slowCnt_q <= slowCnt_d;
         fastTick_q <= fastTick_d;
         slowTick_q <= slowTick_d;
      end
   end

   assign fastTick = fastTick_q;
   assign slowTick = slowTick_q;
endmodule
`default_nettype wire
